//--- rtl/msbl_buffer_layer.sv
// Overview of operation
// - Private 2 KB transmit buffer, separate from host
// - Private 128 B receive buffer, separate from host
// - Host has no access to MAC buffers
// - Receive data reaches host only via FIFO
// - Transmit starts only after whole frame stored
// - Too-full receive FIFO triggers pause frames
// - Alternatively, backpressure by forcing collisions
// - Shared 16 KB host packet memory
// - Transmit/receive split of memory is configurable
// - Separate tx/rx buses carry data and status
// - Control registers use a third bus
// - MAC talks to PHY over internal MII
`timescale 1ns/1ns

module msbl_buf #(
    parameter int AW = 7,
    parameter bit STORE_FWD = 1'b0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire msbl_pkg::msbl_pkt_t in_pkt,
    input wire logic in_valid,
    output logic in_ready,
    output msbl_pkg::msbl_pkt_t out_pkt,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int DEPTH = 1 << AW;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    msbl_pkg::msbl_pkt_t mem [DEPTH];
    msbl_pkg::msbl_pkt_t next_out_pkt;
    logic [AW:0] count, next_count, frames, next_frames;
    logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic next_out_valid, next_in_ready, push, pop, avail;

    // Pointer, fill and stored-frame bookkeeping
    always_comb
    begin
        push = in_valid && in_ready;
        // Store-and-forward waits for a complete frame
        avail = STORE_FWD ? (frames != '0) : (count != '0);
        pop = avail && (!out_valid || out_ready);
        next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
        next_frames = frames + (AW + 1)'(push && in_pkt.last)
            - (AW + 1)'(pop && mem[rd_ptr].last);
        next_wr_ptr = wr_ptr + AW'(push);
        next_rd_ptr = rd_ptr + AW'(pop);
        next_out_pkt = pop ? mem[rd_ptr] : out_pkt;
        next_out_valid = pop || (out_valid && !out_ready);
        // Ready looks ahead so a full buffer never takes a byte
        next_in_ready = next_count != FULL;
    end

    // State registers; storage has no path to the host bus
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            count <= '0;
            frames <= '0;
            wr_ptr <= '0;
            rd_ptr <= '0;
            out_pkt <= msbl_pkg::PKT_RST;
            out_valid <= msbl_pkg::FLAG_RST;
            in_ready <= msbl_pkg::FLAG_RST;
        end
        else
        begin
            count <= next_count;
            frames <= next_frames;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            out_pkt <= next_out_pkt;
            out_valid <= next_out_valid;
            in_ready <= next_in_ready;
        end
    end

    // Payload store, not reset to save area
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_pkt;
        end
    end

    a_fill_bound: assert property (@(posedge clk) disable iff (!nrst)
        count <= FULL)
        else $error("buffer fill above depth");
    a_full_stall: assert property (@(posedge clk) disable iff (!nrst)
        (count == FULL) |-> !in_ready)
        else $error("ready while buffer full");
    a_store_fwd: assert property (@(posedge clk) disable iff (!nrst)
        $rose(out_valid) |-> (!STORE_FWD || $past(frames) != '0))
        else $error("output began before a whole frame");
    a_out_hold: assert property (@(posedge clk) disable iff (!nrst)
        (out_valid && !out_ready) |=> (out_valid && $stable(out_pkt)))
        else $error("stalled output changed");
    c_buf_full: cover property (@(posedge clk) disable iff (!nrst)
        count == FULL);
endmodule

module msbl_buffer_layer (
    input wire logic clk,
    input wire logic nrst,
    input wire msbl_pkg::msbl_pkt_t htx_pkt,
    input wire logic htx_valid,
    output logic htx_ready,
    output msbl_pkg::msbl_pkt_t mtx_pkt,
    output logic mtx_valid,
    input wire logic mtx_ready,
    input wire msbl_pkg::msbl_pkt_t mrx_pkt,
    input wire logic mrx_valid,
    output msbl_pkg::msbl_pkt_t hrx_pkt,
    output logic hrx_valid,
    input wire logic hrx_ready,
    input wire logic [14:0] rx_fifo_used,
    input wire logic [3:0] tx_alloc_kb,
    input wire logic fc_auto_en,
    input wire logic full_duplex,
    output logic pause_req,
    output logic backpressure,
    output logic rx_overrun
);
    logic rx_ready;
    logic [15:0] rx_cap, rx_free;
    logic congested, next_congested;
    logic next_pause_req, next_backpressure, next_rx_overrun;

    // Transmit path: host FIFO into private buffer, then to MII engine
    // on its own bus
    msbl_buf #(
        .AW(msbl_pkg::TX_BUF_AW),
        .STORE_FWD(1'b1)
    ) u_tx_buf (
        .clk(clk),
        .nrst(nrst),
        .in_pkt(htx_pkt),
        .in_valid(htx_valid),
        .in_ready(htx_ready),
        .out_pkt(mtx_pkt),
        .out_valid(mtx_valid),
        .out_ready(mtx_ready)
    );

    // Receive path: data and status words move on to host FIFO
    msbl_buf #(
        .AW(msbl_pkg::RX_BUF_AW),
        .STORE_FWD(1'b0)
    ) u_rx_buf (
        .clk(clk),
        .nrst(nrst),
        .in_pkt(mrx_pkt),
        .in_valid(mrx_valid),
        .in_ready(rx_ready),
        .out_pkt(hrx_pkt),
        .out_valid(hrx_valid),
        .out_ready(hrx_ready)
    );

    // Receive share of packet memory follows the tx allocation
    // Control bits come as ports; register access lives elsewhere
    always_comb
    begin
        rx_cap = msbl_pkg::PKT_MEM_BYTES
            - 16'(tx_alloc_kb * msbl_pkg::ALLOC_UNIT_BYTES);
        // Clamp so a misprogrammed split reads as fully congested
        rx_free = ({1'b0, rx_fifo_used} >= rx_cap) ? 16'h0000
            : rx_cap - {1'b0, rx_fifo_used};
        // Hysteresis keeps pause frames from chattering
        next_congested = congested ? (rx_free < msbl_pkg::FC_OFF_FREE)
            : (rx_free < msbl_pkg::FC_ON_FREE);
        next_pause_req = fc_auto_en && full_duplex
            && next_congested && !congested;
        next_backpressure = fc_auto_en && !full_duplex
            && next_congested;
        // MAC receive engine cannot stall, so a full buffer drops
        next_rx_overrun = mrx_valid && !rx_ready;
    end

    // Flow control and overrun flags
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            congested <= msbl_pkg::FLAG_RST;
            pause_req <= msbl_pkg::FLAG_RST;
            backpressure <= msbl_pkg::FLAG_RST;
            rx_overrun <= msbl_pkg::FLAG_RST;
        end
        else
        begin
            congested <= next_congested;
            pause_req <= next_pause_req;
            backpressure <= next_backpressure;
            rx_overrun <= next_rx_overrun;
        end
    end

    a_pause_cause: assert property (@(posedge clk) disable iff (!nrst)
        pause_req |-> ($past(fc_auto_en) && $past(full_duplex)
            && congested))
        else $error("pause request without cause");
    a_pause_pulse: assert property (@(posedge clk) disable iff (!nrst)
        pause_req |=> !pause_req)
        else $error("pause request longer than one cycle");
    a_bp_half: assert property (@(posedge clk) disable iff (!nrst)
        (fc_auto_en && !full_duplex && rx_fifo_used >= 15'h3A01
            && tx_alloc_kb == 4'h0) |=> backpressure)
        else $error("no backpressure on full fifo");
    a_bp_duplex: assert property (@(posedge clk) disable iff (!nrst)
        backpressure |-> !$past(full_duplex))
        else $error("backpressure in full duplex");
    a_rx_drop: assert property (@(posedge clk) disable iff (!nrst)
        (mrx_valid && !rx_ready) |=> rx_overrun)
        else $error("dropped receive byte not flagged");
    // With 10 KB on transmit only 6 KB is left, so this fill congests
    a_rx_split: assert property (@(posedge clk) disable iff (!nrst)
        (tx_alloc_kb == 4'hA && rx_fifo_used == 15'h1201) |=> congested)
        else $error("receive share ignores the memory split");

    c_tx_frame: cover property (@(posedge clk) disable iff (!nrst)
        mtx_valid && mtx_ready && mtx_pkt.last);
    c_pause: cover property (@(posedge clk) disable iff (!nrst)
        pause_req);
    c_bp: cover property (@(posedge clk) disable iff (!nrst)
        $rose(backpressure));
    c_overrun: cover property (@(posedge clk) disable iff (!nrst)
        rx_overrun);
endmodule

//--- rtl/msbl_pkg.sv
package msbl_pkg;

    // Private MAC-side buffer sizes, as address widths
    localparam int TX_BUF_AW = 11; // 2048 bytes
    localparam int RX_BUF_AW = 7; // 128 bytes

    // Shared host packet memory and its allocation granule
    localparam logic [15:0] PKT_MEM_BYTES = 16'h4000;
    localparam logic [15:0] ALLOC_UNIT_BYTES = 16'h0400;
    localparam int MIN_RX_FRAMES = 200;

    // Free-space thresholds in the host receive FIFO, with hysteresis
    localparam logic [15:0] FC_ON_FREE = 16'h0600;
    localparam logic [15:0] FC_OFF_FREE = 16'h0C00;

    // One byte lane with frame end and an in-band status marker
    typedef struct packed {
        logic [7:0] data;
        logic last;
        logic status;
    } msbl_pkt_t;

    // Values after reset
    localparam msbl_pkt_t PKT_RST = '0;
    localparam logic FLAG_RST = 1'b0;

endpackage

//--- dv/msbl_mac_sink.sv
`timescale 1ns/1ns
// MAC transmit engine stand-in; it can stall to back up the buffer
module msbl_mac_sink (
    input wire logic clk,
    input wire logic stall,
    input wire msbl_pkg::msbl_pkt_t mtx_pkt,
    input wire logic mtx_valid,
    output logic mtx_ready,
    output int n_taken,
    output int n_last
);
    // Ready updates by non-blocking assignment, so it never races stall
    always @(posedge clk)
        mtx_ready <= !stall;
    // Count bytes and frame ends taken
    always @(posedge clk)
        if (mtx_valid && mtx_ready)
        begin
            n_taken <= n_taken + 1;
            n_last <= n_last + mtx_pkt.last;
        end
endmodule

//--- dv/msbl_buffer_layer_tb.sv
`timescale 1ns/1ns
module msbl_buffer_layer_tb;
    typedef struct packed {
        logic [14:0] used;
        logic [3:0] alloc;
        logic auto_en;
        logic fd;
        logic pause;
        logic bp;
    } msbl_fc_row_t;
    // Threshold edges for both allocations, every mode and the enable
    msbl_fc_row_t rows [6] = '{
        '{15'h3A01, 4'h0, 1'b1, 1'b1, 1'b1, 1'b0},
        '{15'h3A00, 4'h0, 1'b1, 1'b1, 1'b0, 1'b0},
        '{15'h3A01, 4'h0, 1'b1, 1'b0, 1'b0, 1'b1},
        '{15'h3A01, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0},
        '{15'h1201, 4'hA, 1'b1, 1'b1, 1'b1, 1'b0},
        '{15'h1800, 4'hA, 1'b1, 1'b0, 1'b0, 1'b1}};
    logic clk = 1'b0, nrst = 1'b0, htx_valid = 1'b0, htx_ready, mtx_valid;
    logic mtx_ready, mrx_valid = 1'b0, hrx_valid, hrx_ready = 1'b0;
    logic stall = 1'b1;
    logic fc_auto_en = 1'b0, full_duplex = 1'b0;
    logic pause_req, backpressure, rx_overrun;
    logic [14:0] rx_fifo_used = '0;
    logic [3:0] tx_alloc_kb = '0;
    logic [15:0] cnt, got;
    msbl_pkg::msbl_pkt_t htx_pkt = '0, mtx_pkt, mrx_pkt = '0, hrx_pkt;
    int n_taken, n_last, n_errors = 0, check_count = 0;

    msbl_buffer_layer u_dut (
        .clk(clk),
        .nrst(nrst),
        .htx_pkt(htx_pkt),
        .htx_valid(htx_valid),
        .htx_ready(htx_ready),
        .mtx_pkt(mtx_pkt),
        .mtx_valid(mtx_valid),
        .mtx_ready(mtx_ready),
        .mrx_pkt(mrx_pkt),
        .mrx_valid(mrx_valid),
        .hrx_pkt(hrx_pkt),
        .hrx_valid(hrx_valid),
        .hrx_ready(hrx_ready),
        .rx_fifo_used(rx_fifo_used),
        .tx_alloc_kb(tx_alloc_kb),
        .fc_auto_en(fc_auto_en),
        .full_duplex(full_duplex),
        .pause_req(pause_req),
        .backpressure(backpressure),
        .rx_overrun(rx_overrun)
    );
    msbl_mac_sink u_mac (.clk(clk), .stall(stall), .mtx_pkt(mtx_pkt),
        .mtx_valid(mtx_valid), .mtx_ready(mtx_ready),
        .n_taken(n_taken), .n_last(n_last));

    initial
        forever #20 clk = !clk;

    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s exp %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Hold the byte until a falling edge sees ready, then pass the edge
    task automatic send(logic [7:0] d, logic last);
        int i;
        htx_pkt = '{d, last, 1'b0};
        htx_valid = 1'b1;
        for (i = 0; htx_ready !== 1'b1; i++)
        begin
            if (i == 3000)
                n_errors++;
            if (i == 3000)
                results();
            @(negedge clk);
        end
        @(negedge clk);
    endtask

    // Watchdog against a hung handshake
    initial
    begin
        repeat (90000) @(posedge clk);
        n_errors++;
        results();
    end

    initial
    begin
        repeat (4) @(negedge clk);
        chk("rst", 16'({htx_ready, mtx_valid, hrx_valid, pause_req,
            backpressure, rx_overrun}), 16'h0000);
        nrst = 1'b1;
        foreach (rows[k])
        begin
            rx_fifo_used = '0;
            tx_alloc_kb = rows[k].alloc;
            fc_auto_en = rows[k].auto_en;
            full_duplex = rows[k].fd;
            repeat (4) @(negedge clk);
            rx_fifo_used = rows[k].used;
            cnt = '0;
            repeat (4)
            begin
                @(negedge clk);
                cnt = cnt + pause_req;
            end
            chk("pause_req", cnt, 16'(rows[k].pause));
            chk("backpressure", 16'(backpressure), 16'(rows[k].bp));
        end
        // Between the two thresholds the congestion state holds
        rx_fifo_used = 15'h1000;
        repeat (4) @(negedge clk);
        chk("bp_hold", 16'(backpressure), 16'h0001);
        rx_fifo_used = 15'h0C00;
        repeat (4) @(negedge clk);
        chk("bp_off", 16'(backpressure), 16'h0000);
        // Nothing leaves before the frame end is stored
        send(8'h11, 0);
        send(8'h22, 0);
        htx_valid = 1'b0;
        repeat (3) @(negedge clk);
        chk("early_tx", 16'(mtx_valid), 16'h0000);
        send(8'h33, 1);
        htx_valid = 1'b0;
        repeat (3) @(negedge clk);
        chk("tx_first", 16'({mtx_valid, mtx_pkt.data}), 16'h0111);
        stall = 1'b0;
        repeat (8) @(negedge clk);
        chk("tx_taken", 16'(n_taken), 16'h0003);
        // Fill the whole transmit buffer while the MAC stalls
        stall = 1'b1;
        for (int i = 0; i < 2048; i++)
            send(i[7:0], i == 2047);
        htx_valid = 1'b0;
        // Look while full: the first byte out frees a slot one edge later
        chk("tx_full", 16'(htx_ready), 16'h0000);
        stall = 1'b0;
        repeat (10) @(negedge clk);
        chk("tx_space", 16'(htx_ready), 16'h0001);
        repeat (2100) @(negedge clk);
        chk("tx_all", 16'(n_taken), 16'h0803);
        chk("tx_frames", 16'(n_last), 16'h0002);
        // Receive byte shows to the host for one cycle after capture
        hrx_ready = 1'b1;
        mrx_pkt = '{8'hA5, 1'b1, 1'b0};
        mrx_valid = 1'b1;
        @(negedge clk);
        mrx_valid = 1'b0;
        @(negedge clk);
        chk("rx_byte", 16'({hrx_valid, hrx_pkt}), 16'h0696);
        // Overflow the receive buffer, then drain it
        repeat (4) @(negedge clk);
        hrx_ready = 1'b0;
        cnt = '0;
        got = '0;
        for (int i = 0; i < 140; i++)
        begin
            mrx_pkt = '{i[7:0], 1'b0, 1'b0};
            mrx_valid = 1'b1;
            @(negedge clk);
            cnt = cnt + rx_overrun;
        end
        mrx_valid = 1'b0;
        hrx_ready = 1'b1;
        // Count the byte on show before the edge that takes it
        repeat (200)
        begin
            got = got + hrx_valid;
            @(negedge clk);
            cnt = cnt + rx_overrun;
        end
        chk("rx_drop", 16'(cnt != 0), 16'h0001);
        chk("rx_sum", cnt + got, 16'h008C);
        // Reset mid-run discards a half-stored frame
        stall = 1'b1;
        send(8'h44, 1'b0);
        htx_valid = 1'b0;
        nrst = 1'b0;
        @(negedge clk);
        chk("rst2", 16'({htx_ready, mtx_valid, hrx_valid, rx_overrun}),
            16'h0000);
        nrst = 1'b1;
        send(8'h55, 1'b1);
        htx_valid = 1'b0;
        repeat (2) @(negedge clk);
        chk("rst2_tx", 16'({mtx_valid, mtx_pkt.data}), 16'h0155);
        results();
    end
endmodule
